// file: rtl/tsr_map.svh
// Register map, reset values and field positions of the temperature result block.
// Contract
// - Reading register is read-only and refreshed at every conversion accepted outside shutdown.
// - Reading is 11-bit two's complement, 0.125 degree steps, left-aligned in 16 bits.
// - A reading read drives all sixteen bits when the controller clocks both bytes.
// - Five low bits of the reading's second byte read as zero.
// - Bit 7 of the first reading byte is the sign bit.
// - A one-byte reading read gives whole degrees and ends after that byte.
// - Trip and release limits are two writable and readable set-point registers.
// - Each limit is 9-bit two's complement in 0.5 degree steps.
// - Limit bits 8..1 fill byte one, bit 0 is byte two bit 7.
// - Every conversion accepted outside shutdown is compared with the trip limit while the alert state is clear, and with the release limit while it is set.
// - Comparison uses only the top nine bits of the reading.
// - Two-bit pointer: 00 reading, 01 config, 10 release, 11 trip; resets to 00.
// - Reset values: trip 5000h, release 4B00h.
// - Comparator style follows limits; interrupt style holds until any register read or shutdown.
// - Alert state changes only after 1, 2, 4 or 6 consecutive faulting conversions.
`ifndef TSR_MAP_SVH
`define TSR_MAP_SVH
`define TSR_PTR_READING   2'h0
`define TSR_PTR_CONFIG    2'h1
`define TSR_PTR_RELEASE   2'h2
`define TSR_PTR_TRIP      2'h3
`define TSR_TRIP_RESET    16'h5000
`define TSR_RELEASE_RESET 16'h4b00
`define TSR_CONFIG_RESET  8'h00
`define TSR_ADDR_HIGH     4'h9
`define TSR_CFG_SHUTDOWN  0
`define TSR_CFG_STYLE     1
`define TSR_CFG_POL       2
`define TSR_CFG_QUEUE_LO  3
`define TSR_CFG_QUEUE_HI  4
`define TSR_QUEUE_1       3'h1
`define TSR_QUEUE_2       3'h2
`define TSR_QUEUE_4       3'h4
`define TSR_QUEUE_6       3'h6
`define TSR_BITS_BYTE     4'h8
`endif

// file: rtl/tsr_pkg.sv
// Types shared by the temperature result block.
package tsr_pkg;
	typedef enum logic [2:0] {
		IDLE,
		ADDR,
		ADDR_ACK,
		WR_BYTE,
		WR_ACK,
		RD_BYTE,
		RD_ACK
	} tsr_bus_e;

	typedef struct packed {
		logic        valid;
		logic [10:0] reading;
	} tsr_conv_s;

	typedef struct packed {
		logic [1:0] queueSel;
		logic       style;
		logic       shutdown;
	} tsr_alert_cfg_s;
endpackage : tsr_pkg

// file: rtl/tsr_sync2.sv
// Two-stage synchroniser for inputs from outside the clock domain.
`timescale 1ns/1ps
module tsr_sync2 #(
	parameter int W = 1
) (
	input  logic         mclk,
	input  logic         resetn,
	input  logic [W-1:0] d,
	output logic [W-1:0] q
);
	import tsr_pkg::*;

	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			logic meta_reg;
			always_ff @(posedge mclk or negedge resetn) begin
				if (!resetn) begin
					meta_reg <= 1'b1;
					q[i]     <= 1'b1;
				end else begin
					meta_reg <= d[i];
					q[i]     <= meta_reg;
				end
			end
		end
	endgenerate
endmodule : tsr_sync2

// file: rtl/tsr_alert.sv
// Limit comparison, fault queue and alert style logic.
`timescale 1ns/1ps
`include "tsr_map.svh"
module tsr_alert (
	input  logic                    mclk,
	input  logic                    resetn,
	input  logic                    conv,
	input  logic [8:0]              reading9,
	input  logic [8:0]              trip9,
	input  logic [8:0]              release9,
	input  tsr_pkg::tsr_alert_cfg_s cfg,
	input  logic                    readStrobe,
	output logic                    alert
);
	import tsr_pkg::*;

	logic       state_reg;
	logic       state_next;
	logic [2:0] cnt_reg;
	logic [2:0] cnt_next;
	logic       alert_next;
	logic       aboveTrip;
	logic       belowRel;
	logic       fault;
	logic       setEvt;
	logic [2:0] need;

	assign aboveTrip = $signed(reading9) > $signed(trip9);
	assign belowRel  = $signed(reading9) < $signed(release9);
	assign fault     = state_reg ? belowRel : aboveTrip;

	always_comb begin
		case (cfg.queueSel)
			2'h0: need = `TSR_QUEUE_1;
			2'h1: need = `TSR_QUEUE_2;
			2'h2: need = `TSR_QUEUE_4;
			default: need = `TSR_QUEUE_6;
		endcase
	end

	always_comb begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		setEvt     = 1'b0;
		if (conv) begin
			if (fault && (cnt_reg + 3'h1) >= need) begin
				state_next = !state_reg;
				cnt_next   = 3'h0;
				setEvt     = 1'b1;
			end else if (fault) begin
				cnt_next = cnt_reg + 3'h1;
			end else begin
				cnt_next = 3'h0;
			end
		end
		if (!cfg.style) begin
			alert_next = state_next;
		end else if (setEvt) begin
			alert_next = 1'b1;
		end else if (readStrobe || cfg.shutdown) begin
			alert_next = 1'b0;
		end else begin
			alert_next = alert;
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			state_reg <= 1'b0;
			cnt_reg   <= 3'h0;
			alert     <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg   <= cnt_next;
			alert     <= alert_next;
		end
	end

	chk_trip_cause: assert property (@(posedge mclk) disable iff (!resetn)
		$rose(state_reg) |-> $past(conv) && $past(aboveTrip))
		else $error("Alert state rose without a conversion above the trip limit.");

	chk_int_read_clear: assert property (@(posedge mclk) disable iff (!resetn)
		cfg.style && readStrobe && !setEvt |=> !alert)
		else $error("Interrupt style alert survived a register read.");

	chk_queue_one: assert property (@(posedge mclk) disable iff (!resetn)
		cfg.queueSel == 2'h0 && conv && fault |=> state_reg != $past(state_reg))
		else $error("Single fault did not change the alert state with queue of one.");
endmodule : tsr_alert

// file: rtl/tsr_result_regs.sv
// Temperature result, limit registers and two-wire slave of the sensor.
`timescale 1ns/1ps
`include "tsr_map.svh"
module tsr_result_regs (
	input  logic               mclk,
	input  logic               resetn,
	input  logic               sclIn,
	input  logic               sdaIn,
	output logic               sdaOut,
	output logic               sdaOe,
	input  logic [2:0]         addrPins,
	input  tsr_pkg::tsr_conv_s convIn,
	output logic               overheatAlertOut,
	output logic               overheatAlertOe,
	output logic               convStop
);
	import tsr_pkg::*;

	logic [4:0]     syncQ;
	logic           sclS;
	logic           sdaS;
	logic [2:0]     addrS;
	logic           sclPrev;
	logic           sdaPrev;
	logic           sclRise;
	logic           sclFall;
	logic           startSeen;
	logic           stopSeen;
	tsr_bus_e       st_reg;
	tsr_bus_e       st_next;
	logic [3:0]     bit_reg;
	logic [3:0]     bit_next;
	logic [7:0]     shift_reg;
	logic [7:0]     shift_next;
	logic [1:0]     byte_reg;
	logic [1:0]     byte_next;
	logic           rw_reg;
	logic           rw_next;
	logic           oe_next;
	logic [15:0]    snap_reg;
	logic [15:0]    snap_next;
	logic           rdLow_reg;
	logic           rdLow_next;
	logic           rdStb_reg;
	logic           rdStb_next;
	logic [1:0]     ptrReg;
	logic [1:0]     ptr_next;
	logic [7:0]     cfgReg;
	logic [7:0]     cfg_next;
	logic [15:0]    tripReg;
	logic [15:0]    trip_next;
	logic [15:0]    releaseReg;
	logic [15:0]    release_next;
	logic [15:0]    readingReg;
	logic [15:0]    reading_next;
	logic [15:0]    selWord;
	logic           convTake;
	logic           alert;
	tsr_alert_cfg_s alertCfg;

	tsr_sync2 #(
		.W(5)
	) u_sync (
		.mclk   (mclk),
		.resetn (resetn),
		.d      ({addrPins, sdaIn, sclIn}),
		.q      (syncQ)
	);

	assign sclS  = syncQ[0];
	assign sdaS  = syncQ[1];
	assign addrS = syncQ[4:2];

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			sclPrev <= 1'b1;
			sdaPrev <= 1'b1;
		end else begin
			sclPrev <= sclS;
			sdaPrev <= sdaS;
		end
	end

	assign sclRise   = sclS && !sclPrev;
	assign sclFall   = !sclS && sclPrev;
	assign startSeen = sclS && sclPrev && sdaPrev && !sdaS;
	assign stopSeen  = sclS && sclPrev && !sdaPrev && sdaS;

	// Word presented for a read, chosen by the pointer.
	always_comb begin
		if (ptrReg == `TSR_PTR_READING) begin
			selWord = readingReg;
		end else if (ptrReg == `TSR_PTR_CONFIG) begin
			selWord = {cfgReg, cfgReg};
		end else if (ptrReg == `TSR_PTR_RELEASE) begin
			selWord = releaseReg;
		end else begin
			selWord = tripReg;
		end
	end

	// A conversion is accepted only while not shut down.
	assign convTake = convIn.valid && !cfgReg[`TSR_CFG_SHUTDOWN];

	always_comb begin
		if (convTake) begin
			reading_next = {convIn.reading, 5'h00};
		end else begin
			reading_next = readingReg;
		end
	end

	always_comb begin
		st_next      = st_reg;
		bit_next     = bit_reg;
		shift_next   = shift_reg;
		byte_next    = byte_reg;
		rw_next      = rw_reg;
		oe_next      = sdaOe;
		snap_next    = snap_reg;
		rdLow_next   = rdLow_reg;
		rdStb_next   = 1'b0;
		ptr_next     = ptrReg;
		cfg_next     = cfgReg;
		trip_next    = tripReg;
		release_next = releaseReg;
		if (stopSeen) begin
			st_next = IDLE;
			oe_next = 1'b0;
		end else if (startSeen) begin
			st_next  = ADDR;
			bit_next = 4'h0;
			oe_next  = 1'b0;
		end else begin
			case (st_reg)
				ADDR: begin
					if (sclRise) begin
						shift_next = {shift_reg[6:0], sdaS};
						bit_next   = bit_reg + 4'h1;
					end else if (sclFall && bit_reg == `TSR_BITS_BYTE) begin
						bit_next = 4'h0;
						if (shift_reg[7:1] == {`TSR_ADDR_HIGH, addrS}) begin
							st_next   = ADDR_ACK;
							oe_next   = 1'b1;
							rw_next   = shift_reg[0];
							byte_next = 2'h0;
						end else begin
							st_next = IDLE;
						end
					end
				end
				ADDR_ACK: begin
					if (sclFall) begin
						bit_next = 4'h0;
						if (rw_reg) begin
							// Snapshot keeps both bytes of one word coherent.
							st_next    = RD_BYTE;
							snap_next  = selWord;
							shift_next = selWord[15:8];
							oe_next    = !selWord[15];
							rdLow_next = 1'b1;
							rdStb_next = 1'b1;
						end else begin
							st_next = WR_BYTE;
							oe_next = 1'b0;
						end
					end
				end
				WR_BYTE: begin
					if (sclRise) begin
						shift_next = {shift_reg[6:0], sdaS};
						bit_next   = bit_reg + 4'h1;
					end else if (sclFall && bit_reg == `TSR_BITS_BYTE) begin
						st_next  = WR_ACK;
						oe_next  = 1'b1;
						bit_next = 4'h0;
						if (byte_reg != 2'h3) begin
							byte_next = byte_reg + 2'h1;
						end
						if (byte_reg == 2'h0) begin
							ptr_next = shift_reg[1:0];
						end else if (byte_reg == 2'h1) begin
							if (ptrReg == `TSR_PTR_CONFIG) begin
								cfg_next = shift_reg;
							end else if (ptrReg == `TSR_PTR_RELEASE) begin
								release_next[15:8] = shift_reg;
							end else if (ptrReg == `TSR_PTR_TRIP) begin
								trip_next[15:8] = shift_reg;
							end
						end else if (byte_reg == 2'h2) begin
							if (ptrReg == `TSR_PTR_RELEASE) begin
								release_next[7:0] = {shift_reg[7], 7'h00};
							end else if (ptrReg == `TSR_PTR_TRIP) begin
								trip_next[7:0] = {shift_reg[7], 7'h00};
							end
						end
						// Data aimed at the reading register is dropped here.
					end
				end
				WR_ACK: begin
					if (sclFall) begin
						st_next = WR_BYTE;
						oe_next = 1'b0;
					end
				end
				RD_BYTE: begin
					if (sclFall && bit_reg == 4'h7) begin
						st_next  = RD_ACK;
						oe_next  = 1'b0;
						bit_next = 4'h0;
					end else if (sclFall) begin
						shift_next = {shift_reg[6:0], 1'b0};
						oe_next    = !shift_reg[6];
						bit_next   = bit_reg + 4'h1;
					end
				end
				RD_ACK: begin
					if (sclRise && sdaS) begin
						// A not-acknowledge ends the read, after one byte or more.
						st_next = IDLE;
					end else if (sclFall) begin
						st_next    = RD_BYTE;
						shift_next = rdLow_reg ? snap_reg[7:0] : snap_reg[15:8];
						oe_next    = rdLow_reg ? !snap_reg[7] : !snap_reg[15];
						rdLow_next = !rdLow_reg;
						bit_next   = 4'h0;
					end
				end
				default: begin
					oe_next = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			st_reg     <= IDLE;
			bit_reg    <= 4'h0;
			shift_reg  <= 8'h00;
			byte_reg   <= 2'h0;
			rw_reg     <= 1'b0;
			sdaOe      <= 1'b0;
			snap_reg   <= 16'h0000;
			rdLow_reg  <= 1'b0;
			rdStb_reg  <= 1'b0;
			ptrReg     <= `TSR_PTR_READING;
			cfgReg     <= `TSR_CONFIG_RESET;
			tripReg    <= `TSR_TRIP_RESET;
			releaseReg <= `TSR_RELEASE_RESET;
			readingReg <= 16'h0000;
		end else begin
			st_reg     <= st_next;
			bit_reg    <= bit_next;
			shift_reg  <= shift_next;
			byte_reg   <= byte_next;
			rw_reg     <= rw_next;
			sdaOe      <= oe_next;
			snap_reg   <= snap_next;
			rdLow_reg  <= rdLow_next;
			rdStb_reg  <= rdStb_next;
			ptrReg     <= ptr_next;
			cfgReg     <= cfg_next;
			tripReg    <= trip_next;
			releaseReg <= release_next;
			readingReg <= reading_next;
		end
	end

	assign alertCfg.queueSel = cfgReg[`TSR_CFG_QUEUE_HI:`TSR_CFG_QUEUE_LO];
	assign alertCfg.style    = cfgReg[`TSR_CFG_STYLE];
	assign alertCfg.shutdown = cfgReg[`TSR_CFG_SHUTDOWN];

	// The new reading is compared in the same cycle that it is stored.
	tsr_alert u_alert (
		.mclk       (mclk),
		.resetn     (resetn),
		.conv       (convTake),
		.reading9   (convIn.reading[10:2]),
		.trip9      (tripReg[15:7]),
		.release9   (releaseReg[15:7]),
		.cfg        (alertCfg),
		.readStrobe (rdStb_reg),
		.alert      (alert)
	);

	// Open-drain pins only ever pull low; polarity picks when the alert pin is pulled.
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			sdaOut           <= 1'b0;
			overheatAlertOut <= 1'b0;
			overheatAlertOe  <= 1'b0;
		end else begin
			sdaOut           <= 1'b0;
			overheatAlertOut <= 1'b0;
			overheatAlertOe  <= alert ^ cfgReg[`TSR_CFG_POL];
		end
	end

	assign convStop = cfgReg[`TSR_CFG_SHUTDOWN];

	chk_reading_refresh: assert property (@(posedge mclk) disable iff (!resetn)
		convTake |=> readingReg == {$past(convIn.reading), 5'h00})
		else $error("Reading not refreshed after a conversion.");

	chk_reading_ro: assert property (@(posedge mclk) disable iff (!resetn)
		!convTake |=> $stable(readingReg))
		else $error("Reading changed without a conversion.");

	chk_reading_low_zero: assert property (@(posedge mclk) disable iff (!resetn)
		readingReg[4:0] == 5'h00)
		else $error("Reading low bits are not zero.");

	chk_limit_low_zero: assert property (@(posedge mclk) disable iff (!resetn)
		tripReg[6:0] == 7'h00 && releaseReg[6:0] == 7'h00)
		else $error("Unused limit bits are not zero.");

	chk_nack_ends_read: assert property (@(posedge mclk) disable iff (!resetn)
		st_reg == RD_ACK && sclRise && sdaS && !stopSeen && !startSeen |=> st_reg == IDLE)
		else $error("Read did not end after a not-acknowledge.");

	chk_read_first_byte: assert property (@(posedge mclk) disable iff (!resetn)
		st_reg == ADDR_ACK && sclFall && rw_reg && ptrReg == `TSR_PTR_READING && !stopSeen && !startSeen
		|=> shift_reg == $past(readingReg[15:8]) ##1 st_reg == RD_BYTE)
		else $error("Reading high byte not loaded at read start.");
endmodule : tsr_result_regs

// file: tb/tsr_bus_ctrl.sv
// Two-wire bus controller model that writes and reads the sensor registers.
`timescale 1ns/1ps
`include "tsr_map.svh"
module tsr_bus_ctrl #(
	parameter logic [2:0] ADDR = 3'h5
) (
	input  logic mclk,
	input  logic sdaLine,
	output logic scl,
	output logic sdaDrive
);
	int nacks = 0;

	initial begin
		scl      = 1'b1;
		sdaDrive = 1'b1;
	end

	// One clock pulse: data is changed in the low phase and sampled mid-high.
	task automatic bit_cycle(input logic b, output logic s);
		repeat (3) @(posedge mclk);
		sdaDrive <= b;
		repeat (4) @(posedge mclk);
		scl <= 1'b1;
		repeat (3) @(posedge mclk);
		s = sdaLine;
		repeat (3) @(posedge mclk);
		scl <= 1'b0;
	endtask : bit_cycle

	task automatic start_cond();
		repeat (3) @(posedge mclk);
		sdaDrive <= 1'b1;
		repeat (3) @(posedge mclk);
		scl <= 1'b1;
		repeat (4) @(posedge mclk);
		sdaDrive <= 1'b0;
		repeat (4) @(posedge mclk);
		scl <= 1'b0;
	endtask : start_cond

	// The clock stays high and the data line is released after a stop.
	task automatic stop_cond();
		repeat (3) @(posedge mclk);
		sdaDrive <= 1'b0;
		repeat (4) @(posedge mclk);
		scl <= 1'b1;
		repeat (3) @(posedge mclk);
		sdaDrive <= 1'b1;
		repeat (6) @(posedge mclk);
	endtask : stop_cond

	task automatic byte_out(input logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_cycle(d[i], s);
		end
		bit_cycle(1'b1, s);
		if (s !== 1'b0) begin
			nacks++;
		end
	endtask : byte_out

	task automatic byte_in(input logic last, output logic [7:0] d);
		logic s;
		logic [7:0] v;
		for (int i = 7; i >= 0; i--) begin
			bit_cycle(1'b1, v[i]);
		end
		bit_cycle(last, s);
		d = v;
	endtask : byte_in

	task automatic write_reg(input logic [1:0] ptr, input int n, input logic [15:0] d);
		start_cond();
		byte_out({`TSR_ADDR_HIGH, ADDR, 1'b0});
		byte_out({6'h00, ptr});
		if (n > 0) begin
			byte_out(d[15:8]);
		end
		if (n > 1) begin
			byte_out(d[7:0]);
		end
		stop_cond();
	endtask : write_reg

	task automatic read_reg(input logic setPtr, input logic [1:0] ptr, input int n, output logic [15:0] d);
		logic [7:0] hi;
		logic [7:0] lo;
		if (setPtr) begin
			write_reg(ptr, 0, 16'h0000);
		end
		start_cond();
		byte_out({`TSR_ADDR_HIGH, ADDR, 1'b1});
		byte_in(n == 1, hi);
		lo = 8'h00;
		if (n > 1) begin
			byte_in(1'b1, lo);
		end
		stop_cond();
		d = {hi, lo};
	endtask : read_reg
endmodule : tsr_bus_ctrl

// file: tb/tb_temp_result_and_limit_regs.sv
// Self-checking bench of the temperature result and limit registers.
`timescale 1ns/1ps
`include "tsr_map.svh"
module tb_temp_result_and_limit_regs;
	import tsr_pkg::*;

	localparam logic [10:0] hotReading  = 11'h0d0;
	localparam logic [10:0] coldReading = 11'h738;

	logic        mclk;
	logic        resetn;
	logic        scl;
	logic        sdaDrive;
	logic        sdaOut;
	logic        sdaOe;
	logic [2:0]  addrPins;
	tsr_conv_s   convIn;
	logic        alertOut;
	logic        alertOe;
	logic        convStop;
	wire         sdaLine;
	logic [15:0] rd;
	int          miscompares = 0;
	int          samplesChecked = 0;

	// Open-drain data line with a pull-up: low when either party pulls it.
	assign sdaLine = sdaDrive & ~sdaOe;

	tsr_bus_ctrl #(.ADDR(3'h5)) i_ctrl (
		.mclk     (mclk),
		.sdaLine  (sdaLine),
		.scl      (scl),
		.sdaDrive (sdaDrive)
	);

	tsr_result_regs i_dut (
		.mclk             (mclk),
		.resetn           (resetn),
		.sclIn            (scl),
		.sdaIn            (sdaLine),
		.sdaOut           (sdaOut),
		.sdaOe            (sdaOe),
		.addrPins         (addrPins),
		.convIn           (convIn),
		.overheatAlertOut (alertOut),
		.overheatAlertOe  (alertOe),
		.convStop         (convStop)
	);

	initial mclk = 1'b0;
	always #5 mclk = ~mclk;

	task finish_test;
		if (miscompares == 0 && samplesChecked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : finish_test

	task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		samplesChecked++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task conv(input logic [10:0] r);
		convIn <= '{valid: 1'b1, reading: r};
		@(posedge mclk);
		convIn.valid <= 1'b0;
		repeat (2) @(posedge mclk);
	endtask : conv

	task test_reset_values;
		i_ctrl.read_reg(1'b0, 2'h0, 2, rd);
		check("reading after reset", rd, 16'h0000);
		i_ctrl.read_reg(1'b1, 2'h3, 2, rd);
		check("trip after reset", rd, 16'h5000);
		i_ctrl.read_reg(1'b1, 2'h2, 2, rd);
		check("release after reset", rd, 16'h4b00);
	endtask : test_reset_values

	task test_reading;
		conv(11'h649);
		i_ctrl.read_reg(1'b1, 2'h0, 2, rd);
		check("negative reading", rd, 16'hc920);
		check("nine bit reading", 16'(rd[15:7]), 16'h0192);
		i_ctrl.read_reg(1'b0, 2'h0, 1, rd);
		check("one byte reading", rd, 16'hc900);
		i_ctrl.write_reg(2'h0, 2, 16'h1234);
		i_ctrl.read_reg(1'b0, 2'h0, 2, rd);
		check("reading after write", rd, 16'hc920);
		conv(11'h001);
		i_ctrl.read_reg(1'b0, 2'h0, 2, rd);
		check("refreshed reading", rd, 16'h0020);
	endtask : test_reading

	task test_limits;
		i_ctrl.write_reg(2'h3, 2, 16'h19ff);
		i_ctrl.read_reg(1'b1, 2'h3, 2, rd);
		check("trip limit", rd, 16'h1980);
		i_ctrl.write_reg(2'h2, 2, 16'h1400);
		i_ctrl.read_reg(1'b1, 2'h2, 2, rd);
		check("release limit", rd, 16'h1400);
	endtask : test_limits

	task test_compare;
		conv(11'h0cf);
		check("alert at trip level", 16'(alertOe), 16'h0000);
		conv(hotReading);
		check("alert above trip", 16'(alertOe), 16'h0001);
		conv(coldReading);
		check("alert below release", 16'(alertOe), 16'h0000);
	endtask : test_compare

	task test_fault_queue;
		int need [4] = '{1, 2, 4, 6};
		for (int q = 0; q < 4; q++) begin
			i_ctrl.write_reg(2'h1, 1, {3'h0, 2'(q), 3'h0, 8'h00});
			for (int k = 1; k < need[q]; k++) begin
				conv(hotReading);
			end
			check("alert before queue full", 16'(alertOe), 16'h0000);
			conv(hotReading);
			check("alert at queue full", 16'(alertOe), 16'h0001);
			i_ctrl.read_reg(1'b0, 2'h1, 2, rd);
			check("config read", rd, {2{3'h0, 2'(q), 3'h0}});
			check("comparator alert after read", 16'(alertOe), 16'h0001);
			for (int k = 0; k < need[q]; k++) begin
				conv(coldReading);
			end
			check("alert after release queue", 16'(alertOe), 16'h0000);
		end
	endtask : test_fault_queue

	task test_interrupt_style;
		i_ctrl.write_reg(2'h1, 1, 16'h0200);
		conv(hotReading);
		check("interrupt alert set", 16'(alertOe), 16'h0001);
		i_ctrl.read_reg(1'b0, 2'h1, 2, rd);
		check("interrupt config read", rd, 16'h0202);
		check("interrupt alert cleared", 16'(alertOe), 16'h0000);
	endtask : test_interrupt_style

	// Active-high polarity inverts the pull-down; shutdown refuses new conversions.
	task test_polarity_shutdown;
		i_ctrl.write_reg(2'h1, 1, 16'h0400);
		check("active high alert set", 16'(alertOe), 16'h0000);
		conv(coldReading);
		check("active high alert clear", 16'(alertOe), 16'h0001);
		i_ctrl.write_reg(2'h1, 1, 16'h0100);
		check("shutdown output", 16'(convStop), 16'h0001);
		conv(hotReading);
		check("alert in shutdown", 16'(alertOe), 16'h0000);
		i_ctrl.read_reg(1'b1, 2'h0, 2, rd);
		check("reading in shutdown", rd, 16'he700);
	endtask : test_polarity_shutdown

	// A second reset in mid-run must restore the shutdown bit, the reading and the trip limit.
	task test_mid_reset;
		resetn <= 1'b0;
		repeat (2) @(posedge mclk);
		resetn <= 1'b1;
		repeat (3) @(posedge mclk);
		check("stop after reset", 16'(convStop), 16'h0000);
		i_ctrl.read_reg(1'b0, 2'h0, 2, rd);
		check("reading after mid reset", rd, 16'h0000);
		i_ctrl.read_reg(1'b1, 2'h3, 2, rd);
		check("trip after mid reset", rd, 16'h5000);
		check("pin drive values", 16'({sdaOut, alertOut}), 16'h0000);
	endtask : test_mid_reset

	initial begin
		for (int i = 0; i < 90000; i++) begin
			@(posedge mclk);
		end
		miscompares++;
		finish_test();
	end

	initial begin
		resetn   = 1'b0;
		addrPins = 3'h5;
		convIn   = '0;
		repeat (10) @(posedge mclk);
		resetn <= 1'b1;
		repeat (3) @(posedge mclk);
		test_reset_values();
		test_reading();
		test_limits();
		test_compare();
		test_fault_queue();
		test_interrupt_style();
		test_polarity_shutdown();
		test_mid_reset();
		check("device acknowledges", 16'(i_ctrl.nacks), 16'h0000);
		finish_test();
	end
endmodule : tb_temp_result_and_limit_regs
